// ===== uart_slp_defs.svh
// Purpose: offsets, field positions, reset values and timing counts for the uart support block
// Assumes: apb byte addresses, one register per aligned 32-bit word
// Notes: definitions only
`ifndef UART_SLP_DEFS_SVH
`define UART_SLP_DEFS_SVH

// register byte offsets
`define OFS_INTEN 12'h004
`define OFS_LNCTL 12'h00c
`define OFS_MDCTL 12'h010
`define OFS_LNSTS 12'h014
`define OFS_ENHF 12'h008
`define OFS_DLL 12'h020
`define OFS_DIVH 12'h024
`define OFS_EVT 12'h028
`define OFS_STS 12'h02c

// field positions
`define INTEN_SLEEP 4
`define ENHF_ENH 4
`define LNCTL_BRK 6
`define LNCTL_DLAB 7
`define MDCTL_PRE4 7
`define MDCTL_IRDA 6

// reset values
`define LNCTL_RST 8'h1d
`define LNSTS_RST 8'h60

// timing
`define TOUT_CHARS 4
`define PRE4_DIV 2'h3

`endif

// ===== uart_slp_pkg.sv
// Purpose: shared types for the uart support block
// Assumes: nothing
// Notes: state encoding is one-hot
package uart_slp_pkg;
  typedef enum logic [1:0] {
    AWAKE = 2'b01,
    ASLEEP = 2'b10
  } pwr_state_t;
endpackage

// ===== uart_sleep_timeout_baud_gen.sv
// Purpose: irq/polled status, auto sleep, rx time-out and break, break send, baud generator
// Assumes: pins synchronous to pclk; fifo and shifter live outside and report flags
// Notes: Behaviour
// Behaviour
// - any low enable bit drives irq
// - sleep needs enhanced and sleep enable bits
// - sleep only when idle, empty, no irq other than holding empty
// - no sleep while rx fifo holds data
// - uart clock stopped while asleep
// - rx, modem pin or tx write wakes
// - gpio transitions never wake the device
// - rx wake works in irda too
// - time-out after four idle character times
// - time-out restarts at stop centre, fifo read
// - break when rx low beyond one character
// - set-break bit holds tx output low
// - sixteen-bit divisor, one to 65535
// - prescaler four when modem bit seven set
// - baud tick is sixteen times bit rate
// - divisor from low and high byte
// - zero divisor gives no baud tick
// - one tick serves transmit and receive
// - divisor bytes reachable only with dlab
`timescale 1ns/10ps
`include "uart_slp_defs.svh"

module uart_sleep_timeout_baud_gen (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial and modem pins
  input wire logic rx_in,
  input wire logic [3:0] modem_in,
  input wire logic [7:0] gpio_in,
  output logic tx_out,
  input wire logic tx_serial,
  // datapath status from fifo and shifter
  input wire logic tx_fifo_empty,
  input wire logic tx_shift_empty,
  input wire logic rx_fifo_has_data,
  input wire logic rx_below_trigger,
  input wire logic rx_stop_centre,
  input wire logic rx_fifo_read,
  input wire logic tx_fifo_write,
  input wire logic [3:0] char_bits,
  input wire logic [3:0] src_pending,
  // outputs
  output logic irq_n,
  output logic uart_clk_en,
  output logic baud_tick,
  output logic asleep,
  output logic [7:0] gpio_state
);

  // ************************************************
  // register file
  // ************************************************
  logic [7:0] interrupt_enable_reg; // low nibble enables, bit 4 sleep
  logic [7:0] line_control_reg; // bit 6 break, bit 7 divisor access
  logic [7:0] modem_control_reg; // bit 7 prescale select
  logic [7:0] enhanced_feature_reg; // bit 4 enhanced functions
  logic [7:0] divisor_low_byte; // divisor lsb
  logic [7:0] divisor_high_byte; // divisor msb
  logic [7:0] line_status_reg; // status seen by polling host
  logic toutf_reg; // sticky time-out event
  logic brkf_reg; // sticky break event
  uart_slp_pkg::pwr_state_t pwr_reg;

  logic wr_acc; // write access phase
  logic rd_acc; // read access phase
  logic dlab; // divisor latch access
  logic clr_evt; // software clears events
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign dlab = line_control_reg[`LNCTL_DLAB];
  // every register is a plain flop, so no access ever needs a wait state;
  // a host therefore sees a fixed two-cycle transfer
  assign pready = 1'b1; // zero wait state slave
  // unmapped, or divisor while locked, answers with an error
  // the error lets software spot a divisor write made with the latch bit clear
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        `OFS_INTEN, `OFS_LNCTL, `OFS_MDCTL, `OFS_LNSTS, `OFS_ENHF,
        `OFS_EVT, `OFS_STS: pslverr = 1'b0;
        `OFS_DLL, `OFS_DIVH: pslverr = !dlab;
        default: pslverr = 1'b1;
      endcase
    end
  end

  function automatic logic hit(input logic [11:0] ofs);
    hit = wr_acc && (paddr == ofs);
  endfunction

  assign clr_evt = hit(`OFS_EVT);

  // control register writes; divisor bytes live in their own block below and are cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_enable_reg <= 8'h00;
      line_control_reg <= `LNCTL_RST;
      modem_control_reg <= 8'h00; // divide-by-1 default
      enhanced_feature_reg <= 8'h00;
    end else if (clk_en) begin
      // writes land on every access-phase edge, so a held request writes again each cycle
      if (hit(`OFS_INTEN)) interrupt_enable_reg <= pwdata[7:0];
      if (hit(`OFS_LNCTL)) line_control_reg <= pwdata[7:0];
      if (hit(`OFS_ENHF)) enhanced_feature_reg <= pwdata[7:0];
      // register writes run on pclk, so they still work while asleep
      if (hit(`OFS_MDCTL)) begin
        // prescale bit only changes with enhanced functions on
        // this keeps legacy software from changing the bit rate by accident
        modem_control_reg[6:0] <= pwdata[6:0];
        if (enhanced_feature_reg[`ENHF_ENH]) modem_control_reg[7] <= pwdata[7];
      end
    end
  end

  // divisor bytes, gated by the access bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_byte <= 8'h00;
      divisor_high_byte <= 8'h00;
    end else if (clk_en) begin
      if (hit(`OFS_DLL) && dlab) divisor_low_byte <= pwdata[7:0];
      // a write while asleep is not blocked; keeping out of it is the host's duty
      if (hit(`OFS_DIVH) && dlab) divisor_high_byte <= pwdata[7:0];
    end
  end

  // ************************************************
  // sleep control
  // ************************************************
  logic sleep_ok; // sleep permitted
  logic can_sleep; // entry conditions hold
  logic wake; // wake event
  logic rx_prev; // last rx sample
  logic [3:0] modem_prev; // last modem sample
  logic other_irq; // irq other than holding empty
  logic rx_idle; // line idle
  // both bits must be set; clearing either one is also a way out of sleep
  // the holding-empty source is left out so an idle transmitter may sleep
  assign sleep_ok = enhanced_feature_reg[`ENHF_ENH] && interrupt_enable_reg[`INTEN_SLEEP];
  assign other_irq = |(src_pending[3:1] & interrupt_enable_reg[3:1]) || toutf_reg || brkf_reg;
  assign rx_idle = rx_in && !rx_fifo_has_data;
  assign can_sleep = sleep_ok && rx_idle && tx_fifo_empty && tx_shift_empty
                     && !other_irq;
  // rx edge is seen in both uart and infrared modes, mode bit is ignored
  // gpio pins are deliberately absent from the wake sum
  assign wake = (rx_in != rx_prev) || (modem_in != modem_prev) || tx_fifo_write;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev <= 1'b1;
      modem_prev <= 4'h0;
    end else if (clk_en) begin
      rx_prev <= rx_in;
      modem_prev <= modem_in;
    end
  end

  // power state: wake restores clock, registers untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= uart_slp_pkg::AWAKE;
    end else if (clk_en) begin
      case (pwr_reg)
        uart_slp_pkg::AWAKE: if (can_sleep && !wake) pwr_reg <= uart_slp_pkg::ASLEEP;
        uart_slp_pkg::ASLEEP: if (wake || !sleep_ok) pwr_reg <= uart_slp_pkg::AWAKE;
        default: pwr_reg <= uart_slp_pkg::AWAKE;
      endcase
    end
  end
  assign asleep = (pwr_reg == uart_slp_pkg::ASLEEP);
  assign uart_clk_en = clk_en && !asleep;
  assign gpio_state = gpio_in; // readable while asleep

  // ************************************************
  // baud generator
  // ************************************************
  logic [15:0] divisor; // full divisor
  logic [1:0] pre_cnt; // prescaler count
  logic pre_tick; // prescaled clock enable
  logic [15:0] div_cnt; // divisor count
  assign divisor = {divisor_high_byte, divisor_low_byte};
  // prescaler gives one enable in four, or every cycle when off
  // the divisor counter only moves on this enable
  assign pre_tick = modem_control_reg[`MDCTL_PRE4] ? (pre_cnt == `PRE4_DIV) : 1'b1;

  // prescaler, frozen while asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 2'h0;
    end else if (uart_clk_en) begin
      pre_cnt <= pre_tick ? 2'h0 : pre_cnt + 2'h1;
    end
  end

  // divisor counter, tick is the 16x clock for both directions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
      baud_tick <= 1'b0;
    end else if (uart_clk_en) begin
      baud_tick <= 1'b0;
      if (divisor == 16'h0000) begin
        div_cnt <= 16'h0000; // no tick at all
      end else if (pre_tick) begin
        if (div_cnt >= divisor - 16'h0001) begin
          div_cnt <= 16'h0000;
          baud_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end else if (clk_en) begin
      baud_tick <= 1'b0;
    end
  end

  // ************************************************
  // time-out and break detect
  // ************************************************
  logic [9:0] tout_cnt; // ticks since last restart
  logic [9:0] brk_cnt; // ticks with rx low
  logic [9:0] char_ticks; // one character in ticks
  assign char_ticks = {2'b00, char_bits, 4'h0}; // bits times sixteen

  // time-out counter, restarted by stop centre or fifo read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_cnt <= 10'h000;
      toutf_reg <= 1'b0;
    end else if (uart_clk_en) begin
      if (rx_stop_centre || rx_fifo_read || !rx_fifo_has_data) begin
        tout_cnt <= 10'h000;
      end else if (baud_tick && tout_cnt != 10'h3ff) begin
        tout_cnt <= tout_cnt + 10'h001;
      end
      // set wins over clear
      if (rx_below_trigger && rx_fifo_has_data && baud_tick
          && tout_cnt + 10'h001 == 10'(char_ticks * `TOUT_CHARS)) begin
        toutf_reg <= 1'b1;
      end else if (clr_evt && pwdata[0]) begin
        toutf_reg <= 1'b0;
      end
    end else if (clk_en && clr_evt && pwdata[0]) begin
      toutf_reg <= 1'b0;
    end
  end

  // break counter, longer than one whole character low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_cnt <= 10'h000;
      brkf_reg <= 1'b0;
    end else if (uart_clk_en) begin
      if (rx_in) brk_cnt <= 10'h000;
      else if (baud_tick && brk_cnt != 10'h3ff) brk_cnt <= brk_cnt + 10'h001;
      if (!rx_in && baud_tick && brk_cnt == char_ticks) begin
        brkf_reg <= 1'b1;
      end else if (clr_evt && pwdata[1]) begin
        brkf_reg <= 1'b0;
      end
    end else if (clk_en && clr_evt && pwdata[1]) begin
      brkf_reg <= 1'b0;
    end
  end

  // ************************************************
  // status, irq and tx pin
  // ************************************************
  // line status: bit 4 break, bits 5,6 transmitter empty, bit 0 data ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // transmitter empty bits set, all else clear
      line_status_reg <= `LNSTS_RST;
    end else if (clk_en) begin
      line_status_reg <= {1'b0, tx_fifo_empty && tx_shift_empty, tx_fifo_empty,
                          brkf_reg, 3'h0, rx_fifo_has_data}; // polled view
    end
  end

  // irq when any low enable matches a pending source or time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n <= 1'b1;
    end else if (clk_en) begin
      irq_n <= !((|(interrupt_enable_reg[3:0] & src_pending))
                 || (interrupt_enable_reg[0] && toutf_reg)
                 || (interrupt_enable_reg[2] && brkf_reg));
    end
  end

  // break send overrides the serializer until bit cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out <= 1'b1;
    end else if (clk_en) begin
      // registered so the pin never glitches when the break bit flips
      // limitation: the pin lags the serializer by one cycle
      tx_out <= line_control_reg[`LNCTL_BRK] ? 1'b0 : tx_serial;
    end
  end

  // read mux, registered data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
        // data is taken in the setup cycle and stands through the access
        // cycle, which trades one cycle of freshness for a flopped output
        `OFS_INTEN: prdata <= {24'h0, interrupt_enable_reg};
        `OFS_LNCTL: prdata <= {24'h0, line_control_reg};
        `OFS_MDCTL: prdata <= {24'h0, modem_control_reg};
        `OFS_LNSTS: prdata <= {24'h0, line_status_reg};
        `OFS_ENHF: prdata <= {24'h0, enhanced_feature_reg};
        // divisor bytes read back as zero while the latch bit is clear
        `OFS_DLL: prdata <= dlab ? {24'h0, divisor_low_byte} : 32'h0;
        `OFS_DIVH: prdata <= dlab ? {24'h0, divisor_high_byte} : 32'h0;
        `OFS_EVT: prdata <= {30'h0, brkf_reg, toutf_reg};
        `OFS_STS: prdata <= {15'h0, asleep, gpio_in, 8'h00};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== uart_far_model.sv
// Purpose: remote serial sender on the receive line
// Assumes: line idles high, as through a pull-up
// Notes: one pclk per step
`timescale 1ns/10ps
module uart_far_model (
  // clock
  input wire logic pclk,
  // line toward the device
  output logic rx_in
);
  initial rx_in = 1'b1;
  // hold the line low for n cycles, then release to idle high
  task automatic line_low(input int n);
    @(posedge pclk);
    rx_in <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_in <= 1'b1;
  endtask
endmodule

// ===== uart_slp_chk.sv
// Purpose: port checks for the uart support block
// Assumes: shadows mirror apb writes; frozen cycles are skipped
// Notes: bound to the top module
`timescale 1ns/10ps
`include "uart_slp_defs.svh"
module uart_slp_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // pins
  input wire logic clk_en,
  input wire logic rx_in,
  input wire logic [3:0] modem_in,
  input wire logic [7:0] gpio_in,
  input wire logic tx_serial,
  input wire logic tx_fifo_write,
  input wire logic rx_fifo_has_data,
  // outputs
  input wire logic tx_out,
  input wire logic uart_clk_en,
  input wire logic baud_tick,
  input wire logic asleep,
  input wire logic [7:0] gpio_state
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, enh_on, slp_on, pre4, cfg_ok; // strobe, shadow bits
  logic [7:0] lnctl, dll, divh; // shadow registers
  logic [17:0] gap, per; // cycles since tick, expected
  assign wr = psel && penable && pwrite && clk_en;
  assign per = {2'h0, divh, dll} << (pre4 ? 2 : 0);
  // mirror host writes; divisor only behind the latch bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lnctl, dll, divh} <= {`LNCTL_RST, 16'h0};
      {enh_on, slp_on, pre4} <= 3'h0;
    end else if (wr) begin
      if (paddr == `OFS_LNCTL) lnctl <= pwdata[7:0];
      if (paddr == `OFS_ENHF) enh_on <= pwdata[`ENHF_ENH];
      if (paddr == `OFS_INTEN) slp_on <= pwdata[`INTEN_SLEEP];
      if (paddr == `OFS_MDCTL && enh_on) pre4 <= pwdata[`MDCTL_PRE4];
      if (paddr == `OFS_DLL && lnctl[`LNCTL_DLAB]) dll <= pwdata[7:0];
      if (paddr == `OFS_DIVH && lnctl[`LNCTL_DLAB]) divh <= pwdata[7:0];
    end
  end
  // trust a period only if it began after the last change or sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 18'h0;
      cfg_ok <= 1'b0;
    end else begin
      gap <= baud_tick ? 18'h1 : gap + 18'h1;
      if (asleep || wr && (paddr[11:4] == 8'h2 || paddr == `OFS_MDCTL)) cfg_ok <= 1'b0;
      else if (baud_tick) cfg_ok <= 1'b1;
    end
  end
  a_break_low: assert property (clk_en && lnctl[`LNCTL_BRK] |=> !tx_out)
    else $error("tx_out high during break");
  a_tx_follow: assert property (
    clk_en && !lnctl[`LNCTL_BRK] |=> tx_out == $past(tx_serial))
    else $error("tx_out not following serializer");
  a_clk_gate: assert property (uart_clk_en == (clk_en && !asleep))
    else $error("uart clock wrong for sleep state");
  a_gpio_read: assert property (gpio_state == gpio_in)
    else $error("gpio state not readable");
  a_sleep_gate: assert property ($rose(asleep) |-> $past(enh_on && slp_on))
    else $error("sleep without enables");
  a_sleep_cond: assert property ($rose(asleep) |-> $past(rx_in && !rx_fifo_has_data))
    else $error("sleep with rx busy or data held");
  a_wake_cause: assert property (
    asleep && (tx_fifo_write || $changed(rx_in) || $changed(modem_in)) |-> ##[1:2] !asleep)
    else $error("no wake after activity");
  a_gpio_nowake: assert property (
    asleep && !psel && !tx_fifo_write && !$past(tx_fifo_write) && $stable(rx_in)
    && $stable(modem_in) && $past(rx_in, 2) == rx_in && $past(modem_in, 2) == modem_in
    |=> asleep)
    else $error("woke without cause");
  a_baud_gap: assert property (baud_tick && cfg_ok |-> gap == per)
    else $error("baud tick period wrong");
  a_baud_off: assert property (
    {divh, dll} == 16'h0 && $past({divh, dll}) == 16'h0 |=> !baud_tick)
    else $error("tick with zero divisor");
  c_sleep: cover property ($rose(asleep));
  c_break: cover property (lnctl[`LNCTL_BRK] && tx_serial);
  c_pre4: cover property (baud_tick && cfg_ok && pre4);
endmodule
bind uart_sleep_timeout_baud_gen uart_slp_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .clk_en, .rx_in, .modem_in, .gpio_in, .tx_serial, .tx_fifo_write,
  .rx_fifo_has_data, .tx_out, .uart_clk_en, .baud_tick, .asleep, .gpio_state);

// ===== tb_top.sv
// Purpose: self-checking bench for the uart support block
// Assumes: zero-wait apb slave, clk_en high except for one freeze check
// Notes: divisor 1 gives one tick a cycle for time-out and break
`timescale 1ns/10ps
`include "uart_slp_defs.svh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0; // clock, reset
  logic clk_en = 1'b1; // dropped once to check the freeze
  logic psel, penable, pwrite, tx_serial, tx_fifo_empty, tx_shift_empty;
  logic rx_fifo_has_data, rx_below_trigger, rx_stop_centre, rx_fifo_read, tx_fifo_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q; // bus data, last read
  logic [3:0] modem_in, char_bits, src_pending;
  logic [7:0] gpio_in, gpio_state;
  logic pready, pslverr, rx_in, tx_out, irq_n, uart_clk_en, baud_tick, asleep, e, last;
  int fails = 0, checks = 0, seed = 32'h11de, i, n, p;
  logic [15:0] d;
  always #5 pclk = ~pclk;
  always @(posedge pclk) gpio_in <= 8'($random(seed));
  uart_sleep_timeout_baud_gen i_uart_sleep_timeout_baud_gen (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_in, .modem_in,
    .gpio_in, .tx_out, .tx_serial, .tx_fifo_empty, .tx_shift_empty, .rx_fifo_has_data,
    .rx_below_trigger, .rx_stop_centre, .rx_fifo_read, .tx_fifo_write, .char_bits,
    .src_pending, .irq_n, .uart_clk_en, .baud_tick, .asleep, .gpio_state);
  uart_far_model i_uart_far_model (.pclk, .rx_in);
  function automatic logic [31:0] exp_per(input logic [15:0] dv, input logic pre);
    return {16'h0, dv} << (pre ? 2 : 0);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] dat);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, dat};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // one-cycle strobe: 0 stop centre, 1 fifo read, 2 tx write
  task automatic pulse(input int k);
    @(posedge pclk);
    {rx_stop_centre, rx_fifo_read, tx_fifo_write} <= 3'b100 >> k;
    @(posedge pclk);
    {rx_stop_centre, rx_fifo_read, tx_fifo_write} <= 3'b000;
  endtask
  // skip two periods, the first possibly stale, then count one whole tick period
  task automatic meas(output int per);
    repeat (2) begin
      n = 0;
      do @(negedge pclk); while (baud_tick !== 1'b1 && ++n < 1100);
    end
    per = 0;
    do begin
      @(negedge pclk);
      per++;
    end while (baud_tick !== 1'b1 && per < 1100);
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    fails++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_serial, tx_fifo_empty, tx_shift_empty} = 50'h7;
    {rx_fifo_has_data, rx_below_trigger, rx_stop_centre, rx_fifo_read, tx_fifo_write} = '0;
    {modem_in, char_bits, src_pending} = 12'h0a0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    acc(`OFS_LNCTL, 0, 0);
    chk(q, 32'h1d);
    acc(`OFS_LNSTS, 0, 0);
    chk(q, 32'h60);
    acc(12'h0f0, 0, 0);
    chk(e, 1);
    acc(`OFS_DLL, 1, 5);
    chk(e, 1);
    acc(`OFS_ENHF, 1, 32'h10);
    acc(`OFS_LNCTL, 1, 32'h80);
    for (i = 0; i < 4; i++) begin
      d = (i == 3) ? 16'h0100 : 16'(($random(seed) & 7) + 2);
      acc(`OFS_DLL, 1, {24'h0, d[7:0]});
      acc(`OFS_DIVH, 1, {24'h0, d[15:8]});
      acc(`OFS_MDCTL, 1, {24'h0, i[0], 7'h0});
      meas(p);
      chk(p, exp_per(d, i[0]));
    end
    acc(`OFS_DLL, 1, 0);
    acc(`OFS_DIVH, 1, 0);
    repeat (3) @(negedge pclk);
    p = 0;
    repeat (60) @(negedge pclk) p += (baud_tick !== 1'b0);
    chk(p, 0);
    acc(`OFS_DLL, 1, 1);
    acc(`OFS_MDCTL, 1, 0);
    acc(`OFS_LNCTL, 1, 3);
    {rx_fifo_has_data, rx_below_trigger} <= 2'b11;
    pulse(0);
    repeat (400) @(posedge pclk);
    pulse(1);
    repeat (590) @(posedge pclk);
    acc(`OFS_EVT, 0, 0);
    chk(q & 1, 0);
    repeat (100) @(posedge pclk);
    acc(`OFS_EVT, 0, 0);
    chk(q & 1, 1);
    acc(`OFS_EVT, 1, 3);
    rx_fifo_has_data <= 1'b0;
    i_uart_far_model.line_low(140);
    acc(`OFS_EVT, 0, 0);
    chk(q & 2, 0);
    i_uart_far_model.line_low(200);
    acc(`OFS_EVT, 0, 0);
    chk(q & 2, 2);
    acc(`OFS_EVT, 1, 3);
    acc(`OFS_LNCTL, 1, 32'h43);
    for (i = 0; i < 32; i++) begin
      if (i == 16) acc(`OFS_LNCTL, 1, 3);
      @(posedge pclk);
      last = tx_serial;
      tx_serial <= 1'($random(seed));
      @(negedge pclk);
      chk(tx_out, (i < 16) ? 1'b0 : last);
    end
    // freeze: the tx pin must hold while the enable is low
    @(posedge pclk);
    last = tx_serial;
    {clk_en, tx_serial} <= {1'b0, ~tx_serial};
    repeat (3) @(negedge pclk);
    chk(tx_out, last);
    @(posedge pclk);
    clk_en <= 1'b1;
    for (i = 0; i < 5; i++) begin
      acc(`OFS_INTEN, 1, (i < 4) ? 32'h1 << i : 32'h0);
      src_pending <= (i < 4) ? 4'h1 << i : 4'hf;
      repeat (3) @(negedge pclk);
      chk(irq_n, i == 4);
    end
    {src_pending, rx_fifo_has_data} <= 5'h01;
    acc(`OFS_INTEN, 1, 32'h10);
    repeat (10) @(negedge pclk);
    chk(asleep, 0);
    @(posedge pclk);
    rx_fifo_has_data <= 1'b0;
    for (i = 0; i < 4; i++) begin
      if (i == 3) acc(`OFS_MDCTL, 1, 32'h40);
      repeat (10) @(negedge pclk);
      chk({asleep, uart_clk_en}, 2'b10);
      chk(gpio_state, gpio_in);
      @(posedge pclk);
      if (i == 1) modem_in <= ~modem_in;
      else fork
        if (i == 2) pulse(2); else i_uart_far_model.line_low(4);
      join_none
      n = 0;
      do @(negedge pclk); while (asleep !== 1'b0 && ++n < 6);
      chk(32'(n < 6), 1);
    end
    summarize();
  end
endmodule
